// *** shared/e1fca_map.vh ***
`ifndef E1FCA_MAP_VH
`define E1FCA_MAP_VH
`define E1FCA_REG_CTRL 2'h0
`define E1FCA_REG_STAT 2'h1
`define E1FCA_REG_NAT 2'h2
`define E1FCA_REG_CERR 2'h3
`define E1FCA_CTRL_RESET 13'h00a1
`define E1FCA_B_CRC_EN 0
`define E1FCA_B_IW_DIS 1
`define E1FCA_B_CSC 2
`define E1FCA_B_AAD 3
`define E1FCA_B_TE 4
`define E1FCA_B_HDB3 5
`define E1FCA_B_TRANSMIT_ALARM_LEVEL 6
`define E1FCA_B_CSC_ALT 7
`define E1FCA_B_SA_LO 8
`define E1FCA_FAS_PAT 7'h1b
`define E1FCA_MFAS_PAT 6'h0b
`define E1FCA_CRC_POLY 4'h3
`define E1FCA_CLK_HZ 20000000
`define E1FCA_BIT_HZ 2048000
`define E1FCA_FRAME_US 125
`define E1FCA_MF_TIMEOUT_MS 400
`define E1FCA_REFRAME_MS 8
`define E1FCA_SECOND_MS 1000
`define E1FCA_CRC_ERR_LIMIT 914
`define E1FCA_FAS_LOSS 3
`endif

// *** src/e1fca_crc4.v ***
`timescale 1ns/1ps
`include "e1fca_map.vh"
module e1fca_crc4
(
	input wire clk,
	input wire reset_n,
	input wire en,
	input wire clear,
	input wire din,
	output reg [3:0] crc
);
	// Clear restarts from zero on the first bit of a submultiframe
	wire [3:0] base = clear ? 4'h0 : crc;
	wire fb = din ^ base[3];
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			crc <= 4'h0;
		else if (en)
			crc <= {base[2:0], 1'b0} ^ (fb ? `E1FCA_CRC_POLY : 4'h0);
	end
endmodule

// *** src/e1fca_line.v ***
`timescale 1ns/1ps
module e1fca_line
(
	input wire clk,
	input wire reset_n,
	input wire en,
	input wire hdb3,
	input wire tx_bit,
	output reg tx_pos,
	output reg tx_neg,
	input wire rx_pos,
	input wire rx_neg,
	output reg rx_bit,
	output reg rx_valid
);
	reg [3:0] m;
	reg [3:0] v;
	reg par;
	reg pol;
	reg [3:0] d;
	reg lpol;
	wire [3:0] ms = {m[2:0], tx_bit};
	wire sub = hdb3 & (ms == 4'h0);
	wire par_now = v[3] ? 1'b0 : (par ^ m[3]);
	wire mark = rx_pos | rx_neg;
	wire viol = hdb3 & mark & (rx_pos == lpol);
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			m <= 4'h0;
			v <= 4'h0;
			par <= 1'b0;
			pol <= 1'b0;
			tx_pos <= 1'b0;
			tx_neg <= 1'b0;
			d <= 4'h0;
			lpol <= 1'b0;
			rx_bit <= 1'b0;
			rx_valid <= 1'b0;
		end
		else
		begin
			rx_valid <= en;
			if (en)
			begin
				// Four bits of look-ahead cost four bits of latency each way
				tx_pos <= m[3] & (v[3] ? pol : ~pol);
				tx_neg <= m[3] & (v[3] ? ~pol : pol);
				if (m[3] & ~v[3])
					pol <= ~pol;
				par <= par_now;
				m <= sub ? {~par_now, 2'b00, 1'b1} : ms;
				v <= sub ? 4'h1 : {v[2:0], 1'b0};
				rx_bit <= d[3];
				d <= viol ? 4'h0 : {d[2:0], mark};
				if (mark)
					lpol <= rx_pos;
			end
		end
	end
endmodule

// *** src/e1fca_top.v ***
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "e1fca_map.vh"
module e1fca_top
#(
	parameter CLK_HZ = `E1FCA_CLK_HZ,
	parameter BIT_HZ = `E1FCA_BIT_HZ,
	parameter [13:0] MF_TIMEOUT_FRAMES = `E1FCA_MF_TIMEOUT_MS * 1000 / `E1FCA_FRAME_US,
	parameter [13:0] REFRAME_FRAMES = `E1FCA_REFRAME_MS * 1000 / `E1FCA_FRAME_US,
	parameter [13:0] SECOND_FRAMES = `E1FCA_SECOND_MS * 1000 / `E1FCA_FRAME_US
)
(
	input wire clk,
	input wire reset_n,
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	input wire tx_payload,
	output reg [4:0] tx_chan,
	output reg tx_strobe,
	output reg rx_payload,
	output reg [4:0] rx_chan,
	output reg rx_strobe,
	output wire line_tx_pos,
	output wire line_tx_neg,
	input wire line_rx_pos,
	input wire line_rx_neg
);
	localparam [3:0] S_SRCH = 4'b0001;
	localparam [3:0] S_NFAS = 4'b0010;
	localparam [3:0] S_FAS = 4'b0100;
	localparam [3:0] S_SYNC = 4'b1000;
	localparam [24:0] ACC_STEP = BIT_HZ[24:0];
	localparam [24:0] ACC_TOP = CLK_HZ[24:0];
	localparam [6:0] FAS_BITS = `E1FCA_FAS_PAT;
	localparam [5:0] MFAS_BITS = `E1FCA_MFAS_PAT;

	function [4:0] chan_of;
		input [4:0] ts;
		begin
			if (ts == 5'd0 || ts == 5'd16)
				chan_of = 5'd0;
			else if (ts < 5'd16)
				chan_of = ts;
			else
				chan_of = ts - 5'd1;
		end
	endfunction

	reg [12:0] ctrl;
	reg [4:0] tx_nat;
	reg [24:0] acc;
	reg bit_en;
	reg [2:0] tb;
	reg [4:0] tts;
	reg [3:0] tfr;
	reg [3:0] tx_rem;
	reg tx_bit;
	reg rx_p1, rx_p2, rx_n1, rx_n2;
	reg [3:0] state;
	reg [2:0] rb;
	reg [4:0] rts;
	reg [3:0] rfr;
	reg [5:0] rsh;
	reg [5:0] mfsh;
	reg [1:0] fas_err;
	reg mf_sync;
	reg iw_status;
	reg [3:0] rc_rx;
	reg [3:0] rc_prev;
	reg chk_arm;
	reg e1_ok, e2_ok;
	reg [13:0] mf_tmr;
	reg [13:0] rf_tmr;
	reg [13:0] sec_tmr;
	reg [9:0] cerr;
	reg [4:0] rx_nat;
	reg far_rai;
	wire [3:0] tcrc;
	wire [3:0] rcrc;
	wire rx_d;
	wire rx_v;

	wire crc_en = ctrl[`E1FCA_B_CRC_EN];
	wire iw_dis = ctrl[`E1FCA_B_IW_DIS];
	wire csc = ctrl[`E1FCA_B_CSC];
	wire aad = ctrl[`E1FCA_B_AAD];
	wire te = ctrl[`E1FCA_B_TE];
	wire transmit_alarm_level = ctrl[`E1FCA_B_TRANSMIT_ALARM_LEVEL];
	wire csc_alt = ctrl[`E1FCA_B_CSC_ALT];
	wire [4:0] sa_sel = ctrl[`E1FCA_B_SA_LO+4:`E1FCA_B_SA_LO];
	wire fsync = state[3];
	wire mf_tmo = (mf_tmr >= MF_TIMEOUT_FRAMES);
	// Interworking off: the alternate sync bit cleared ends the search
	wire search_act = crc_en & ~mf_sync & iw_status & ~(iw_dis & ~csc_alt);
	wire rai_tx = aad ? (~fsync & transmit_alarm_level)
		: (~fsync | (iw_dis & mf_tmo & search_act));
	wire tx_fas = ~tfr[0];
	wire tx_cpos = (tts == 5'd0) & tx_fas & (tb == 3'd0);
	wire tx_smf = (tts == 5'd0) & (tb == 3'd0) & (tfr[2:0] == 3'd0);

	// Transmit bit selection for the current position
	always @*
	begin
		tx_bit = 1'b1;
		if (tts == 5'd0)
		begin
			if (tx_fas)
			begin
				if (tb == 3'd0)
					// The first C bit leaves on the edge that loads the remainder, so it is taken live
					tx_bit = ~crc_en ? 1'b1 : (tx_smf ? tcrc[3] : tx_rem[~tfr[2:1]]);
				else
					tx_bit = FAS_BITS[3'd7 - tb];
			end
			else
			begin
				case (tb)
					3'd0:
						if (!crc_en)
							tx_bit = 1'b1;
						else if (tfr[3:1] < 3'd6)
							tx_bit = MFAS_BITS[3'd5 - tfr[3:1]];
						else
							tx_bit = tfr[1] ? e2_ok : e1_ok;
					3'd1:
						tx_bit = 1'b1;
					3'd2:
						tx_bit = rai_tx;
					default:
						tx_bit = sa_sel[tb - 3'd3] ? tx_nat[tb - 3'd3] : 1'b1;
				endcase
			end
		end
		else if (tts != 5'd16)
			tx_bit = tx_payload;
	end

	e1fca_crc4 u_tcrc
	(
		.clk(clk),
		.reset_n(reset_n),
		.en(bit_en),
		.clear(tx_smf),
		.din(tx_cpos ? 1'b0 : tx_bit),
		.crc(tcrc)
	);

	e1fca_line u_line
	(
		.clk(clk),
		.reset_n(reset_n),
		.en(bit_en),
		.hdb3(ctrl[`E1FCA_B_HDB3]),
		.tx_bit(tx_bit),
		.tx_pos(line_tx_pos),
		.tx_neg(line_tx_neg),
		.rx_pos(rx_p2),
		.rx_neg(rx_n2),
		.rx_bit(rx_d),
		.rx_valid(rx_v)
	);

	// Fractional divider: 20 MHz is no integer multiple of the bit rate
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			acc <= 25'h0;
			bit_en <= 1'b0;
			tb <= 3'h0;
			tts <= 5'h0;
			tfr <= 4'h0;
			tx_rem <= 4'h0;
			tx_chan <= 5'h0;
			tx_strobe <= 1'b0;
			rx_p1 <= 1'b0;
			rx_p2 <= 1'b0;
			rx_n1 <= 1'b0;
			rx_n2 <= 1'b0;
		end
		else
		begin
			rx_p1 <= line_rx_pos;
			rx_p2 <= rx_p1;
			rx_n1 <= line_rx_neg;
			rx_n2 <= rx_n1;
			if (acc + ACC_STEP >= ACC_TOP)
			begin
				acc <= acc + ACC_STEP - ACC_TOP;
				bit_en <= 1'b1;
			end
			else
			begin
				acc <= acc + ACC_STEP;
				bit_en <= 1'b0;
			end
			tx_chan <= chan_of(tts);
			tx_strobe <= bit_en;
			if (bit_en)
			begin
				if (tx_smf)
					tx_rem <= tcrc;
				tb <= tb + 3'd1;
				if (tb == 3'd7)
				begin
					tts <= tts + 5'd1;
					if (tts == 5'd31)
						tfr <= tfr + 4'd1;
				end
			end
		end
	end

	wire fr_end = rx_v & (rts == 5'd31) & (rb == 3'd7);
	wire [6:0] rwin = {rsh, rx_d};
	wire r_fas = ~rfr[0];
	wire r_ts0 = rx_v & (rts == 5'd0);
	wire r_smf = r_ts0 & (rb == 3'd0) & (rfr[2:0] == 3'd0);
	wire r_cpos = (rts == 5'd0) & r_fas & (rb == 3'd0);
	wire do_chk = r_smf & mf_sync & iw_status & chk_arm;
	wire cerr_bad = do_chk & (rc_rx != rc_prev);
	wire fas_end = r_ts0 & r_fas & (rb == 3'd7);
	wire fas_bad = fas_end & (rwin != `E1FCA_FAS_PAT);
	wire timed = fsync & search_act & ~csc;
	wire force_rf = (fr_end & timed & (rf_tmr + 14'd1 >= REFRAME_FRAMES))
		| (cerr_bad & (cerr >= `E1FCA_CRC_ERR_LIMIT));
	wire lose = fsync & fas_bad & (fas_err == `E1FCA_FAS_LOSS - 1);

	e1fca_crc4 u_rcrc
	(
		.clk(clk),
		.reset_n(reset_n),
		.en(rx_v),
		.clear(r_smf),
		.din(r_cpos ? 1'b0 : rx_d),
		.crc(rcrc)
	);

	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state <= S_SRCH;
			rb <= 3'h0;
			rts <= 5'h0;
			rfr <= 4'h0;
			rsh <= 6'h0;
			mfsh <= 6'h0;
			fas_err <= 2'h0;
			mf_sync <= 1'b0;
			iw_status <= 1'b1;
			rc_rx <= 4'h0;
			rc_prev <= 4'h0;
			chk_arm <= 1'b0;
			e1_ok <= 1'b1;
			e2_ok <= 1'b1;
			mf_tmr <= 14'h0;
			rf_tmr <= 14'h0;
			sec_tmr <= 14'h0;
			cerr <= 10'h0;
			rx_nat <= 5'h1f;
			far_rai <= 1'b0;
			rx_payload <= 1'b0;
			rx_chan <= 5'h0;
			rx_strobe <= 1'b0;
		end
		else
		begin
			rx_strobe <= rx_v & fsync & (chan_of(rts) != 5'd0);
			if (rx_v)
			begin
				rx_payload <= rx_d;
				rx_chan <= chan_of(rts);
				rsh <= rwin[5:0];
				rb <= rb + 3'd1;
				if (rb == 3'd7)
				begin
					rts <= rts + 5'd1;
					if (rts == 5'd31)
						rfr <= rfr + 4'd1;
				end
				if (r_ts0 & ~r_fas & (rb == 3'd2))
					far_rai <= rx_d;
				if (r_ts0 & ~r_fas & (rb >= 3'd3) & fsync)
					rx_nat[rb - 3'd3] <= rx_d;
				if (r_cpos)
					rc_rx <= {rc_rx[2:0], rx_d};
			end
			// Receive alignment state machine
			case (state)
				S_SRCH:
					if (rx_v & (rwin == `E1FCA_FAS_PAT))
					begin
						rb <= 3'd0;
						rts <= 5'd1;
						rfr <= 4'd0;
						state <= S_NFAS;
					end
				S_NFAS:
					if (r_ts0 & ~r_fas & (rb == 3'd1))
						state <= rx_d ? S_FAS : S_SRCH;
				S_FAS:
					if (fas_end)
						state <= fas_bad ? S_SRCH : S_SYNC;
				S_SYNC:
					if (lose | force_rf)
						state <= S_SRCH;
				default:
					state <= S_SRCH;
			endcase
			if (fas_end)
				fas_err <= fas_bad ? fas_err + 2'd1 : 2'd0;
			if (~fsync | ~crc_en)
			begin
				mf_sync <= 1'b0;
				chk_arm <= 1'b0;
			end
			else if (r_ts0 & ~r_fas & (rb == 3'd0) & search_act)
			begin
				mfsh <= {mfsh[4:0], rx_d};
				if ({mfsh[4:0], rx_d} == `E1FCA_MFAS_PAT)
				begin
					mf_sync <= 1'b1;
					rfr <= 4'd11;
				end
			end
			if (r_smf)
			begin
				rc_prev <= rcrc;
				chk_arm <= mf_sync;
			end
			// E-bits fall back to the TE level whenever checking is off
			if (~(mf_sync & iw_status))
			begin
				e1_ok <= te;
				e2_ok <= te;
			end
			else if (do_chk)
			begin
				// The check at frame 8 judges submultiframe 2 of the previous multiframe, the one at frame 0 judges 1
				if (rfr[3])
					e1_ok <= ~cerr_bad;
				else
					e2_ok <= ~cerr_bad;
			end
			// Per-second error count; the limit acts within the second
			if (fr_end & (sec_tmr + 14'd1 >= SECOND_FRAMES))
			begin
				sec_tmr <= 14'h0;
				cerr <= 10'h0;
			end
			else
			begin
				if (fr_end)
					sec_tmr <= sec_tmr + 14'd1;
				if (force_rf)
					cerr <= 10'h0;
				else if (cerr_bad)
					cerr <= cerr + 10'd1;
			end
			// A forced reframe keeps the 400 ms timer; a true loss restarts it
			if (lose | ~crc_en | mf_sync)
				mf_tmr <= 14'h0;
			else if (fr_end & timed & ~mf_tmo)
				mf_tmr <= mf_tmr + 14'd1;
			if (~fsync | force_rf | ~timed)
				rf_tmr <= 14'h0;
			else if (fr_end)
				rf_tmr <= rf_tmr + 14'd1;
			if (lose | ~crc_en)
				iw_status <= 1'b1;
			else if (~iw_dis & ~csc & mf_tmo & fsync)
				iw_status <= 1'b0;
		end
	end

	reg [31:0] rd_mux;
	always @*
	begin
		rd_mux = 32'h0;
		if (avs_address[1:0] == 2'b00)
		begin
			case (avs_address[3:2])
				`E1FCA_REG_CTRL:
					rd_mux = {19'h0, ctrl};
				`E1FCA_REG_STAT:
					rd_mux = {19'h0, rx_nat, 2'b00, search_act, far_rai, rai_tx, iw_status, mf_sync, fsync};
				`E1FCA_REG_NAT:
					rd_mux = {27'h0, tx_nat};
				default:
					rd_mux = {22'h0, cerr};
			endcase
		end
	end

	// One wait cycle, then the answer; writes land on the accepting edge
	wire wr_go = avs_write & ~avs_waitrequest & (avs_address[1:0] == 2'b00);
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0;
			ctrl <= `E1FCA_CTRL_RESET;
			tx_nat <= 5'h1f;
		end
		else
		begin
			if ((avs_read | avs_write) & avs_waitrequest)
			begin
				avs_waitrequest <= 1'b0;
				avs_readdata <= avs_read ? rd_mux : 32'h0;
			end
			else
				avs_waitrequest <= 1'b1;
			if (wr_go & (avs_address[3:2] == `E1FCA_REG_CTRL))
			begin
				if (avs_byteenable[0])
					ctrl[7:0] <= avs_writedata[7:0];
				if (avs_byteenable[1])
					ctrl[12:8] <= avs_writedata[12:8];
			end
			if (wr_go & (avs_address[3:2] == `E1FCA_REG_NAT) & avs_byteenable[0])
				tx_nat <= avs_writedata[4:0];
		end
	end
endmodule

// *** verification/e1fca_chk.sv ***
`timescale 1ns/1ps
module e1fca_chk
#(
	parameter CLK_HZ = 20000000,
	parameter BIT_HZ = 2048000
)
(
	input wire clk,
	input wire reset_n,
	input wire avs_read,
	input wire avs_write,
	input wire avs_waitrequest,
	input wire [4:0] tx_chan,
	input wire tx_strobe,
	input wire [4:0] rx_chan,
	input wire rx_strobe,
	input wire line_tx_pos,
	input wire line_tx_neg
);
	localparam int GLO = CLK_HZ / BIT_HZ;
	localparam int GHI = GLO + 1;
	reg [4:0] prev;
	reg [4:0] gap;
	reg [3:0] cnt;
	reg seen;
	reg gseen;
	wire chg = tx_chan != prev;
	// First slot and first gap after reset may be partial, so they are not judged
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			prev <= 5'h0;
			gap <= 5'h0;
			cnt <= 4'h0;
			seen <= 1'b0;
			gseen <= 1'b0;
		end
		else
		begin
			prev <= tx_chan;
			gap <= tx_strobe ? 5'h1 : gap + 5'h1;
			gseen <= gseen | tx_strobe;
			seen <= seen | chg;
			cnt <= chg ? {3'h0, tx_strobe} : cnt + {3'h0, tx_strobe};
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_answer;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	sequence s_quiet;
		(!rx_strobe)[*3];
	endsequence
	property p_bus_answer;
		(avs_read || avs_write) && avs_waitrequest |=> s_answer;
	endproperty
	property p_rails;
		!(line_tx_pos && line_tx_neg);
	endproperty
	property p_tx_range;
		tx_chan <= 5'h1e;
	endproperty
	property p_tx_step;
		chg |-> (tx_chan == 5'h0) ? (prev == 5'hf || prev == 5'h1e) :
			(prev == 5'h0 ? (tx_chan == 5'h1 || tx_chan == 5'h10) : tx_chan == prev + 5'h1);
	endproperty
	property p_rx_range;
		rx_strobe |-> rx_chan != 5'h0 && rx_chan <= 5'h1e;
	endproperty
	property p_tx_gap;
		tx_strobe && gseen |-> gap >= GLO && gap <= GHI;
	endproperty
	property p_rx_gap;
		rx_strobe |=> s_quiet;
	endproperty
	property p_slot_len;
		chg && seen |-> cnt == 4'h8;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("bus answer not one cycle");
	a_rails: assert property (p_rails) else $error("both line rails high");
	a_tx_range: assert property (p_tx_range) else $error("tx channel out of range");
	a_tx_step: assert property (p_tx_step) else $error("tx channel order wrong");
	a_rx_range: assert property (p_rx_range) else $error("rx channel out of range");
	a_tx_gap: assert property (p_tx_gap) else $error("tx bit spacing wrong");
	a_rx_gap: assert property (p_rx_gap) else $error("rx bits too close");
	a_slot_len: assert property (p_slot_len) else $error("slot not eight bits");
endmodule

bind e1fca_top e1fca_chk #(.CLK_HZ(CLK_HZ), .BIT_HZ(BIT_HZ)) i_chk
(
	.clk(clk),
	.reset_n(reset_n),
	.avs_read(avs_read),
	.avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest),
	.tx_chan(tx_chan),
	.tx_strobe(tx_strobe),
	.rx_chan(rx_chan),
	.rx_strobe(rx_strobe),
	.line_tx_pos(line_tx_pos),
	.line_tx_neg(line_tx_neg)
);

// *** verification/e1fca_far_end.sv ***
`timescale 1ns/1ps
module e1fca_far_end
(
	input wire cut,
	input wire tx_pos,
	input wire tx_neg,
	output wire rx_pos,
	output wire rx_neg
);
	// Loop-timed far end returns our own frames
	// A cut line carries no marks, as a dead span would
	assign rx_pos = tx_pos & ~cut;
	assign rx_neg = tx_neg & ~cut;
endmodule

// *** verification/e1fca_top_test.sv ***
`timescale 1ns/1ps
module e1fca_top_test;
	reg clk = 1'b0;
	reg reset_n = 1'b0;
	reg [3:0] avs_address = 4'h0;
	reg avs_read = 1'b0;
	reg avs_write = 1'b0;
	reg [31:0] avs_writedata = 32'h0;
	reg tx_payload = 1'b0;
	reg cut = 1'b0;
	reg [31:0] st = 32'h0;
	wire [31:0] avs_readdata;
	wire avs_waitrequest;
	wire [4:0] tx_chan;
	wire [4:0] rx_chan;
	wire tx_strobe;
	wire rx_payload;
	wire rx_strobe;
	wire ltp;
	wire ltn;
	wire lrp;
	wire lrn;
	integer fails = 0;
	integer compares = 0;
	always #25 clk = ~clk;
	always @(posedge clk)
		if (tx_strobe)
			tx_payload <= ~tx_payload;
	// Faster bit rate keeps multiframe acquisition inside the run budget
	// Reframe span must exceed a multiframe plus alignment, or acquisition never completes
	e1fca_top #(.BIT_HZ(5000000), .MF_TIMEOUT_FRAMES(14'd48), .REFRAME_FRAMES(14'd40),
		.SECOND_FRAMES(14'd40)) i_dut
	(
		.clk(clk),
		.reset_n(reset_n),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(4'h3),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.tx_payload(tx_payload),
		.tx_chan(tx_chan),
		.tx_strobe(tx_strobe),
		.rx_payload(rx_payload),
		.rx_chan(rx_chan),
		.rx_strobe(rx_strobe),
		.line_tx_pos(ltp),
		.line_tx_neg(ltn),
		.line_rx_pos(lrp),
		.line_rx_neg(lrn)
	);
	e1fca_far_end i_far
	(
		.cut(cut),
		.tx_pos(ltp),
		.tx_neg(ltn),
		.rx_pos(lrp),
		.rx_neg(lrn)
	);
	task chk(input [31:0] got, input [31:0] exp);
	begin
		compares = compares + 1;
		if (got !== exp)
		begin
			fails = fails + 1;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask
	// Bench payload flips every bit, so received bits must flip within a slot
	reg [4:0] rx_last = 5'h0;
	reg rx_lastbit = 1'b0;
	always @(posedge clk)
		if (cut)
			rx_last <= 5'h0;
		else if (rx_strobe)
		begin
			if (rx_chan == rx_last)
				chk({31'h0, rx_payload}, {31'h0, ~rx_lastbit});
			rx_last <= rx_chan;
			rx_lastbit <= rx_payload;
		end
	task bus(input wr, input [3:0] a, input [31:0] d);
	begin
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= ~wr;
		avs_write <= wr;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge clk);
		st = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	end
	endtask
	task poll(input [31:0] m, input [31:0] v);
		integer i;
	begin
		bus(1'b0, 4'h4, 32'h0);
		for (i = 0; i < 30000 && (st & m) !== v; i = i + 1)
			bus(1'b0, 4'h4, 32'h0);
	end
	endtask
	task finish_test;
	begin
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask
	initial
	begin
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		bus(1'b0, 4'h0, 32'h0);
		chk(st, 32'ha1);
		bus(1'b0, 4'h8, 32'h0);
		chk(st, 32'h1f);
		// Unmapped write must not alias onto the control word
		bus(1'b1, 4'h1, 32'h0);
		bus(1'b0, 4'h0, 32'h0);
		chk(st, 32'ha1);
		bus(1'b1, 4'h8, 32'h15);
		bus(1'b1, 4'h0, 32'h1fa1);
		bus(1'b0, 4'h0, 32'h0);
		chk(st, 32'h1fa1);
		poll(32'h3, 32'h3);
		chk(st & 32'h1f1b, 32'h1503);
		cut <= 1'b1;
		poll(32'h1, 32'h0);
		chk(st & 32'h9, 32'h8);
		bus(1'b1, 4'h0, 32'h1fa9);
		poll(32'h9, 32'h0);
		chk(st & 32'h9, 32'h0);
		bus(1'b1, 4'h0, 32'h1fe9);
		poll(32'h9, 32'h8);
		chk(st & 32'h9, 32'h8);
		cut <= 1'b0;
		poll(32'h1, 32'h1);
		chk(st & 32'h9, 32'h1);
		finish_test;
	end
	initial
	begin
		#(90000 * 50);
		fails = fails + 1;
		finish_test;
	end
endmodule
